// ==== core/tbt_regs.svh ====
// Register map, field positions, reset values and counter taps of the timebase timer
`ifndef TBT_REGS_SVH
`define TBT_REGS_SVH

// Register byte address, kept as word index [31:2]
`define TBT_CTRL_WORD      30'h00000000

// Control/status field positions
`define TBT_BIT_FLAG       7
`define TBT_BIT_IE         6
`define TBT_BIT_SEL_HI     2
`define TBT_BIT_SEL_LO     1
`define TBT_BIT_INIT       0

// Reset values
`define TBT_RST_FLAG       1'b0
`define TBT_RST_IE         1'b0
`define TBT_RST_SEL        2'h0

// Counter geometry: bit k overflows every 2^(k+2) main periods
`define TBT_CNT_W          21
`define TBT_TAP_W          5
`define TBT_TAP_INT0       5'h0b
`define TBT_TAP_INT1       5'h0d
`define TBT_TAP_INT2       5'h10
`define TBT_TAP_INT3       5'h14
`define TBT_TAP_STAB0      5'h0c
`define TBT_TAP_STAB1      5'h0f
`define TBT_TAP_STAB2      5'h10

// Derived clock bits: bit m has period 2^(m+2) main periods
`define TBT_CLK_WDT        19
`define TBT_CLK_ADC        6
`define TBT_CLK_LCD        9

// AXI responses
`define TBT_RESP_OKAY      2'h0
`define TBT_RESP_SLVERR    2'h2

`endif

// ==== core/tbt_pkg.sv ====
// Types and reset state of the timebase timer
package tbt_pkg;

`include "tbt_regs.svh"

    typedef struct packed {
        logic [`TBT_CNT_W-1:0] cnt;
        logic                  phase;
        logic                  flag;
        logic                  ie;
        logic [1:0]            sel;
        logic                  hold_q;
        logic                  stab_ok;
        logic                  wdt_clr;
        logic                  wdt_clk;
        logic                  adc_clk;
        logic                  lcd_clk;
        logic                  irq;
        logic                  aw_ok;
        logic                  aw_hit;
        logic                  w_ok;
        logic [7:0]            wbyte;
        logic                  wlane;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } tbt_state_t;

    localparam tbt_state_t TBT_STATE_RST = '{
        flag    : `TBT_RST_FLAG,
        ie      : `TBT_RST_IE,
        sel     : `TBT_RST_SEL,
        awready : 1'b1,
        wready  : 1'b1,
        arready : 1'b1,
        default : '0
    };

endpackage

// ==== core/tbt_top.sv ====
// Timebase interval timer with AXI4-Lite control/status register
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns


module tbt_top
    import tbt_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // AXI4-Lite slave
    input  wire logic [31:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [31:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // Clock controller side
    input  wire logic        i_main_stop,
    input  wire logic        i_subclk_mode,
    input  wire logic [1:0]  i_stab_wait_sel,
    input  wire logic        i_wdt_src_sel,
    // Outputs to processor and peripherals
    output logic             o_timebase_irq,
    output logic             o_osc_stable,
    output logic             o_wdt_clear,
    output logic             o_wdt_clk,
    output logic             o_adc_clk,
    output logic             o_lcd_clk
);

    // =========================================================
    // Helper functions
    // =========================================================

    // True when bits [b:0] of c are all ones, so the
    // next count clock carries out of bit b
    function automatic logic tap_ovf(
        input logic [`TBT_CNT_W-1:0] c,
        input logic [`TBT_TAP_W-1:0] b
    );
        logic r;
        r = 1'b1;
        for (int i = 0; i < `TBT_CNT_W; i++)
        begin
            if ((`TBT_TAP_W'(i) <= b) && !c[i])
            begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // Interval select to tap bit
    // Tap k overflows every 2^(k+2) main periods
    function automatic logic [`TBT_TAP_W-1:0] int_tap(input logic [1:0] s);
        logic [`TBT_TAP_W-1:0] t;
        case (s)
            2'h0:    t = `TBT_TAP_INT0;
            2'h1:    t = `TBT_TAP_INT1;
            2'h2:    t = `TBT_TAP_INT2;
            2'h3:    t = `TBT_TAP_INT3;
            default: t = `TBT_TAP_INT0;
        endcase
        return t;
    endfunction

    // Stabilization wait select to tap bit
    // Selects 2 and 3 both give the longest wait
    function automatic logic [`TBT_TAP_W-1:0] stab_tap(input logic [1:0] s);
        logic [`TBT_TAP_W-1:0] t;
        case (s)
            2'h0:    t = `TBT_TAP_STAB0;
            2'h1:    t = `TBT_TAP_STAB1;
            default: t = `TBT_TAP_STAB2;
        endcase
        return t;
    endfunction

    // Register word address match; low address bits ignored
    function automatic logic is_ctrl(input logic [31:0] a);
        return a[31:2] == `TBT_CTRL_WORD;
    endfunction

    // Read image of the control/status byte
    function automatic logic [7:0] ctrl_image(
        input logic       f,
        input logic       e,
        input logic [1:0] s
    );
        logic [7:0] v;
        v = 8'h00;
        v[`TBT_BIT_FLAG] = f;
        v[`TBT_BIT_IE]   = e;
        v[`TBT_BIT_SEL_HI:`TBT_BIT_SEL_LO] = s;
        v[`TBT_BIT_INIT] = 1'b1;
        return v;
    endfunction

    // =========================================================
    // State
    // =========================================================

    tbt_state_t st;
    tbt_state_t next_st;

    logic       hold;
    logic       hold_rise;
    logic       aw_take;
    logic       w_take;
    logic       ar_take;
    logic       do_wr;
    logic       wr_ctrl;
    logic       sw_clr;
    logic       any_clr;
    logic       tick;
    logic       ovf_int;
    logic       ovf_stab;
    logic [7:0] rd_byte;

    always_comb
    begin
        next_st   = st;

        // =====================================================
        // Mode hold and clear sources
        // =====================================================
        // Both modes stop the main oscillator, so the
        // counter is held at zero while either is high
        hold      = i_main_stop | i_subclk_mode;
        hold_rise = hold & ~st.hold_q;
        next_st.hold_q = hold;

        // =====================================================
        // AXI4-Lite write path
        // =====================================================
        // The write acts one edge after both halves are in,
        // so address and data may come in either order
        aw_take = i_awvalid & st.awready;
        w_take  = i_wvalid & st.wready;
        do_wr   = st.aw_ok & st.w_ok & ~st.bvalid;

        if (aw_take)
        begin
            next_st.aw_ok  = 1'b1;
            next_st.aw_hit = is_ctrl(i_awaddr);
        end
        if (w_take)
        begin
            next_st.w_ok  = 1'b1;
            next_st.wbyte = i_wdata[7:0];
            next_st.wlane = i_wstrb[0];
        end
        if (st.bvalid && i_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        if (do_wr)
        begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = st.aw_hit ? `TBT_RESP_OKAY : `TBT_RESP_SLVERR;
        end
        next_st.awready = ~next_st.aw_ok & ~next_st.bvalid;
        next_st.wready  = ~next_st.w_ok & ~next_st.bvalid;

        // Low byte lane carries the whole register
        wr_ctrl = do_wr & st.aw_hit & st.wlane;
        sw_clr  = wr_ctrl & ~st.wbyte[`TBT_BIT_INIT];
        any_clr = sw_clr | hold;

        // =====================================================
        // Counter
        // =====================================================
        // Phase halves the main clock into the count clock;
        // a clear zeroes it too, so the first tick lands
        // two edges after the clear
        tick = st.phase;
        if (any_clr)
        begin
            next_st.cnt   = '0;
            next_st.phase = 1'b0;
        end
        else
        begin
            next_st.phase = ~st.phase;
            if (tick)
            begin
                next_st.cnt = st.cnt + `TBT_CNT_W'(1);
            end
        end

        // Carry out of the tap bit on a tick; a clear in the
        // same cycle wins and suppresses it
        ovf_int  = ~any_clr & tick & tap_ovf(st.cnt, int_tap(st.sel));
        ovf_stab = ~any_clr & tick & tap_ovf(st.cnt, stab_tap(i_stab_wait_sel));

        // =====================================================
        // Control/status register
        // =====================================================
        if (wr_ctrl)
        begin
            next_st.ie  = st.wbyte[`TBT_BIT_IE];
            next_st.sel = st.wbyte[`TBT_BIT_SEL_HI:`TBT_BIT_SEL_LO];
            if (!st.wbyte[`TBT_BIT_FLAG])
            begin
                next_st.flag = 1'b0;
            end
        end
        // Overflow beats a flag clear in the same cycle; the
        // count runs through the stabilization wait, so a
        // short interval sets the flag before resume
        if (ovf_int)
        begin
            next_st.flag = 1'b1;
        end
        next_st.irq = next_st.flag & next_st.ie;

        // =====================================================
        // Stabilization wait
        // =====================================================
        // Wait restarts with every hold and ends at the
        // first overflow of the tap the clock controller picks
        if (hold)
        begin
            next_st.stab_ok = 1'b0;
        end
        else if (ovf_stab)
        begin
            next_st.stab_ok = 1'b1;
        end

        // =====================================================
        // Derived clocks and watchdog clear
        // =====================================================
        // One pulse per clear while i_wdt_src_sel is low, on the edge that zeroes the
        // count; a long hold does not repeat it
        next_st.wdt_clr = (sw_clr | hold_rise) & ~i_wdt_src_sel;
        // Clocks follow the registered count, so a clear
        // restarts them low
        next_st.wdt_clk = next_st.cnt[`TBT_CLK_WDT];
        next_st.adc_clk = next_st.cnt[`TBT_CLK_ADC];
        next_st.lcd_clk = next_st.cnt[`TBT_CLK_LCD];

        // =====================================================
        // AXI4-Lite read path
        // =====================================================
        // Bits 5:3 hold no storage and read back as zero
        rd_byte = ctrl_image(st.flag, st.ie, st.sel);

        // Read data is captured at the address handshake and
        // held until taken; unmapped reads return zero
        ar_take = i_arvalid & st.arready;
        if (st.rvalid && i_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take)
        begin
            next_st.rvalid = 1'b1;
            if (is_ctrl(i_araddr))
            begin
                next_st.rdata = {24'h000000, rd_byte};
                next_st.rresp = `TBT_RESP_OKAY;
            end
            else
            begin
                next_st.rdata = 32'h00000000;
                next_st.rresp = `TBT_RESP_SLVERR;
            end
        end
        next_st.arready = ~next_st.rvalid;
    end

    // =========================================================
    // State register
    // =========================================================

    // Power-on reset zeroes the count and starts a
    // stabilization wait
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= TBT_STATE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================

    // Every output is a field of the state register
    assign o_awready      = st.awready;
    assign o_wready       = st.wready;
    assign o_bvalid       = st.bvalid;
    assign o_bresp        = st.bresp;
    assign o_arready      = st.arready;
    assign o_rvalid       = st.rvalid;
    assign o_rdata        = st.rdata;
    assign o_rresp        = st.rresp;
    assign o_timebase_irq = st.irq;
    assign o_osc_stable   = st.stab_ok;
    assign o_wdt_clear    = st.wdt_clr;
    assign o_wdt_clk      = st.wdt_clk;
    assign o_adc_clk      = st.adc_clk;
    assign o_lcd_clk      = st.lcd_clk;

endmodule

// ==== verif/tbt_properties.sv ====
// Port-level timing checks of the timebase timer
`timescale 1ns/1ns

module tbt_properties
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_main_stop,
    input wire logic        i_subclk_mode,
    input wire logic        i_wdt_src_sel,
    input wire logic        i_bready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_rvalid,
    input wire logic        o_timebase_irq,
    input wire logic        o_osc_stable,
    input wire logic        o_wdt_clear,
    input wire logic        o_adc_clk
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic        hold;
    logic [15:0] low_cnt;
    logic [8:0]  hi_cnt;

    assign hold = i_main_stop | i_subclk_mode;

    // Length of the unstable phase and of the A/D clock high phase
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            low_cnt <= '0;
            hi_cnt  <= '0;
        end
        else
        begin
            low_cnt <= o_osc_stable ? 16'h0 : ((low_cnt == 16'hffff) ? low_cnt : low_cnt + 16'h1);
            hi_cnt  <= o_adc_clk ? hi_cnt + 9'h1 : 9'h0;
        end
    end

    property p_rdata_fixed;
        o_rvalid && o_rresp == 2'h0 |-> o_rdata[0] && o_rdata[31:8] == 24'h0;
    endproperty
    a_rdata_fixed: assert property (p_rdata_fixed) else $error("read data fixed bits wrong");
    property p_hold_unstable;
        hold |=> !o_osc_stable;
    endproperty
    a_hold_unstable: assert property (p_hold_unstable) else $error("stable while held");
    property p_stab_min;
        $rose(o_osc_stable) |-> low_cnt >= 16'h3e80;
    endproperty
    a_stab_min: assert property (p_stab_min) else $error("stabilization wait too short");
    property p_wdt_on_hold;
        $rose(hold) && !i_wdt_src_sel |-> ##[1:2] o_wdt_clear;
    endproperty
    a_wdt_on_hold: assert property (p_wdt_on_hold) else $error("no watchdog clear on hold");
    property p_wdt_pulse;
        o_wdt_clear |=> !o_wdt_clear;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear too long");
    property p_wdt_src;
        i_wdt_src_sel [*3] |-> !o_wdt_clear;
    endproperty
    a_wdt_src: assert property (p_wdt_src) else $error("watchdog clear with other source");
    property p_irq_drop;
        $fell(o_timebase_irq) |-> $rose(o_bvalid);
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("request dropped without write");
    property p_bresp_hold;
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response not held");
    property p_adc_high;
        $fell(o_adc_clk) |-> hi_cnt <= 9'h080 && hi_cnt != 9'h0;
    endproperty
    a_adc_high: assert property (p_adc_high) else $error("A/D clock high phase too long");
endmodule

bind tbt_top tbt_properties tbt_properties_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_main_stop(i_main_stop),
    .i_subclk_mode(i_subclk_mode), .i_wdt_src_sel(i_wdt_src_sel), .i_bready(i_bready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .o_timebase_irq(o_timebase_irq), .o_osc_stable(o_osc_stable), .o_wdt_clear(o_wdt_clear),
    .o_adc_clk(o_adc_clk));

// ==== verif/test_tbt_top.sv ====
// Self-checking bench of the timebase timer
`timescale 1ns/1ns

module test_tbt_top;
    logic        i_mclk = 0, i_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        main_stop = 0, subclk = 0, wdt_src = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, irq, stable, wclr, wclk, aclk, lclk;
    logic [1:0]  stab_sel = 2'h0;
    int          miscompares = 0, total_checks = 0, cyc = 0, seed = 32'hac35, pulses = 0, clears = 0;
    int          flag = 0, ie = 0, sel = 0, n;

    tbt_top tbt_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_main_stop(main_stop), .i_subclk_mode(subclk), .i_stab_wait_sel(stab_sel), .i_wdt_src_sel(wdt_src),
        .o_timebase_irq(irq), .o_osc_stable(stable), .o_wdt_clear(wclr), .o_wdt_clk(wclk), .o_adc_clk(aclk),
        .o_lcd_clk(lclk));

    initial forever #20 i_mclk = ~i_mclk;

    // ==========================================
    // Tasks
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        awaddr <= a;
        wdata <= {24'($random(seed)), v};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1'($random(seed));
        do
        begin
            @(posedge i_mclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid && !bready) bready <= 1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge i_mclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge i_mclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    function automatic logic [31:0] exp_reg();
        return {24'h0, flag[0], ie[0], 3'h0, sel[1:0], 1'h1};
    endfunction

    // Derived clock level e main periods after a clear, half period h
    function automatic logic dclk(input int e, input int h);
        return 1'((e / h) % 2);
    endfunction

    task automatic mwr(input logic [7:0] v);
        wr(32'h0, v);
        chk("bresp", 32'(r), 32'h0);
        ie = v[6];
        sel = v[2:1];
        if (!v[7]) flag = 0;
        if (!v[0] && !wdt_src) clears++;
    endtask

    task automatic period(input int s);
        int p;
        p = (s == 0) ? 8192 : 32768;
        mwr(8'h40 | 8'(s << 1));
        n = 1;
        while (!irq)
        begin
            @(posedge i_mclk);
            n++;
        end
        flag = 1;
        chk("period", 32'(n >= p - 4 && n <= p + 4), 32'h1);
    endtask

    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (wclr) pulses <= pulses + 1;
        if (cyc == 98000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge i_mclk);
        i_rst <= 0;
        rd(32'h0);
        chk("reset", d, exp_reg());
        wstrb <= 4'h0;
        wr(32'h0, 8'h46);
        wstrb <= 4'hf;
        rd(32'h0);
        chk("no strobe", d, exp_reg());
        d = {$random(seed)} | 32'h4;
        wr(d, 8'h00);
        chk("bad wr", 32'(r), 32'h2);
        rd(d);
        chk("bad rd", {rdata[29:0], r}, 32'h2);
        for (int s = 0; s < 4; s++)
        begin
            mwr(8'h81 | 8'(s << 1) | (8'($random(seed)) & 8'h38));
            rd(32'h0);
            chk("select", d, exp_reg());
        end
        period(0);
        rd(32'h0);
        chk("flag", d, exp_reg());
        mwr(8'h81);
        chk("irq off", 32'(irq), 32'h0);
        rd(32'h0);
        chk("flag kept", d, exp_reg());
        mwr(8'hc1);
        chk("irq now", 32'(irq), 32'h1);
        mwr(8'h41);
        chk("irq clr", 32'(irq), 32'h0);
        period(1);
        stab_sel <= 2'h1;
        mwr(8'h04);
        main_stop <= 1;
        repeat (20) @(posedge i_mclk);
        clears++;
        main_stop <= 0;
        repeat (33000) @(posedge i_mclk);
        d = 32'({dclk(32999, 1048576), dclk(32999, 128), dclk(32999, 1024)});
        chk("derived clk", 32'({wclk, aclk, lclk}), d);
        chk("stab sel1 long", 32'(stable), 32'h0);
        rd(32'h0);
        chk("sel2 long", d, exp_reg());
        stab_sel <= 2'h0;
        mwr(8'h40);
        main_stop <= 1;
        repeat (20) @(posedge i_mclk);
        clears++;
        chk("held", 32'({irq, stable}), 32'h0);
        main_stop <= 0;
        n = 0;
        while (!stable)
        begin
            @(posedge i_mclk);
            n++;
        end
        chk("stab", 32'(n >= 16380 && n <= 16388), 32'h1);
        chk("resume irq", 32'(irq), 32'h1);
        wdt_src <= 1;
        @(posedge i_mclk);
        subclk <= 1;
        repeat (4) @(posedge i_mclk);
        subclk <= 0;
        repeat (4) @(posedge i_mclk);
        chk("wdt clears", pulses, clears);
        conclude();
    end
endmodule
